// ---- src/dscp_pkg.sv ----
`default_nettype none

package dscp_pkg;

    // ------------------------------------------------------------
    // register space
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W    = 5;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned NUM_REGS  = 32;
    localparam logic [4:0]  CFG_ADDR  = 5'h00;
    localparam logic [4:0]  ADDR_TOP  = 5'h1f;
    localparam logic [7:0]  CFG_RESET = 8'h00;
    localparam logic [7:0]  REG_RESET = 8'h00;  // default of registers 01h..1fh

    // ------------------------------------------------------------
    // fields of register 00h and of the instruction byte
    // ------------------------------------------------------------
    localparam int unsigned CFG_BIDIR_BIT = 7;
    localparam int unsigned CFG_LSB_BIT   = 6;
    localparam int unsigned CFG_SRST_BIT  = 5;
    localparam int unsigned INS_RW_BIT    = 7;
    localparam int unsigned BIT_LAST      = 7;

    typedef struct packed {
        logic       rd;
        logic [1:0] count_m1;   // byte_count_hi, byte_count_lo
        logic [4:0] addr;       // start_addr_bit4 is addr[4]
    } dscp_instr_t;

    typedef struct packed {
        logic       stb;
        logic [4:0] addr;
        logic [7:0] data;
    } dscp_wr_t;

    typedef enum logic [1:0] {
        DSCP_INSTR = 2'b00,
        DSCP_DATA  = 2'b01,
        DSCP_DONE  = 2'b10
    } dscp_state_t;

endpackage

`default_nettype wire

// ---- src/dscp_regfile.sv ----
`timescale 1ns/100ps
`default_nettype none

module dscp_regfile (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire dscp_pkg::dscp_wr_t wr,
    input  wire logic              clr,
    input  wire logic [4:0]        rd_addr,
    output logic [7:0]             rd_data
);

    logic [7:0] mem_q [dscp_pkg::NUM_REGS];

    // ------------------------------------------------------------
    // storage; clear restores defaults of everything above 00h
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dscp_pkg::NUM_REGS; i++) begin
                mem_q[i] <= dscp_pkg::REG_RESET;
            end
        end else if (clr) begin
            for (int i = 1; i < dscp_pkg::NUM_REGS; i++) begin
                mem_q[i] <= dscp_pkg::REG_RESET;
            end
        end else if (wr.stb) begin
            mem_q[wr.addr] <= wr.data;
        end
    end

    // registered read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= dscp_pkg::REG_RESET;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule

`default_nettype wire

// ---- src/dscp_port.sv ----
`timescale 1ns/100ps
`default_nettype none

// Function
// - Every incoming bit is sampled on a serial clock rising edge.
// - Every read data bit is launched on a serial clock falling edge.
// - Shifting only happens while select is low.
// - Select high puts both data outputs in high impedance.
// - Register 00h bit 7 makes the data pin bidirectional; reset is input-only.
// - In bidirectional mode the separate output pin is never driven.
// - Register 00h bit 6 selects LSB-first order; reset is MSB-first.
// - LSB-first shifts low bit first and increments address per byte.
// - MSB-first shifts high bit first and decrements address per byte.
// - Address wraps 1Fh to 00h upward and 00h to 1Fh downward.
// - New port configuration applies right after its byte completes.
// - Software reset defaults all registers except register 00h.
// - Mirrored pattern to 00h reconfigures and resets in either bit order.
// - Instruction bit 7 high means read, low means write.
// - Instruction bits 6:5 give byte count minus one, bits 4:0 address.
// - Select high then low restarts at instruction; partial byte dropped.
// - Each data byte is written as soon as its last bit arrives.

module dscp_port (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             sclk,
    input  wire logic             port_select_n,
    input  wire logic             sdio_i,
    output logic                  sdio_o,
    output logic                  sdio_oe,
    output logic                  serial_data_out_pin_o,
    output logic                  serial_data_out_pin_oe,
    output logic [7:0]            cfg_reg,
    output dscp_pkg::dscp_wr_t    reg_wr,
    output logic                  soft_reset
);

    // ------------------------------------------------------------
    // pin synchronisers and edge finding
    // ------------------------------------------------------------
    logic [1:0] sclk_sy_q, cs_sy_q, din_sy_q;
    logic       sclk_prev_q;
    logic       rise, fall, cs_hi, din;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sy_q   <= 2'b00;
            cs_sy_q     <= 2'b11;
            din_sy_q    <= 2'b00;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_sy_q   <= {sclk_sy_q[0], sclk};
            cs_sy_q     <= {cs_sy_q[0], port_select_n};
            din_sy_q    <= {din_sy_q[0], sdio_i};
            sclk_prev_q <= sclk_sy_q[1];
        end
    end

    // all three pins share the same latency, so data stays aligned with its edge
    assign cs_hi = cs_sy_q[1];
    assign din   = din_sy_q[1];
    assign rise  = ~cs_hi & sclk_sy_q[1] & ~sclk_prev_q;
    assign fall  = ~cs_hi & ~sclk_sy_q[1] & sclk_prev_q;

    // ------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------
    dscp_pkg::dscp_state_t state_q;
    dscp_pkg::dscp_instr_t ins_q;
    logic [2:0] bit_q;
    logic [6:0] sh_q;
    logic [1:0] left_q;
    logic [4:0] addr_q;
    logic [7:0] rx_byte, rd_mem, tx_byte;
    logic       lsb_first, bidir, byte_done, wr_cycle;
    logic       rd_phase_q;
    logic [4:0] next_addr;

    assign lsb_first = cfg_reg[dscp_pkg::CFG_LSB_BIT];
    assign bidir     = cfg_reg[dscp_pkg::CFG_BIDIR_BIT];

    // assemble the arriving byte in the current bit order
    function automatic logic [7:0] order_byte(input logic [6:0] sh, input logic b,
                                              input logic lsb);
        logic [7:0] r;
        r = lsb ? {b, sh} : {sh, b};
        return r;
    endfunction

    function automatic logic [4:0] step_addr(input logic [4:0] a, input logic up);
        return up ? 5'(a + 5'd1) : 5'(a - 5'd1);
    endfunction

    assign rx_byte   = order_byte(sh_q, din, lsb_first);
    assign byte_done = rise && (bit_q == 3'(dscp_pkg::BIT_LAST)) && state_q != dscp_pkg::DSCP_DONE;
    assign wr_cycle  = byte_done && state_q == dscp_pkg::DSCP_DATA && !ins_q.rd;
    // step uses the configuration in force after this byte, so 00h edits apply at once
    assign next_addr = step_addr(addr_q, (wr_cycle && addr_q == dscp_pkg::CFG_ADDR)
                       ? rx_byte[dscp_pkg::CFG_LSB_BIT] : lsb_first);

    // bit counter and shift register; select high drops any partial byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= 3'd0;
            sh_q  <= 7'd0;
        end else if (cs_hi) begin
            bit_q <= 3'd0;
        end else if (rise) begin
            bit_q <= 3'(bit_q + 3'd1);
            sh_q  <= lsb_first ? rx_byte[7:1] : rx_byte[6:0];
        end
    end

    // phase sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= dscp_pkg::DSCP_INSTR;
            ins_q   <= '0;
            left_q  <= 2'd0;
            addr_q  <= dscp_pkg::CFG_ADDR;
        end else if (cs_hi) begin
            state_q <= dscp_pkg::DSCP_INSTR;
        end else if (byte_done) begin
            if (state_q == dscp_pkg::DSCP_INSTR) begin
                ins_q   <= rx_byte;
                left_q  <= rx_byte[6:5];
                addr_q  <= rx_byte[4:0];
                state_q <= dscp_pkg::DSCP_DATA;
            end else begin
                addr_q <= next_addr;
                left_q <= 2'(left_q - 2'd1);
                if (left_q == 2'd0) begin
                    state_q <= dscp_pkg::DSCP_DONE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // register writes, port configuration and software reset
    // ------------------------------------------------------------
    logic cfg_hit;
    assign cfg_hit = wr_cycle && addr_q == dscp_pkg::CFG_ADDR;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_wr <= '0;
        end else begin
            reg_wr.stb  <= wr_cycle;
            reg_wr.addr <= addr_q;
            reg_wr.data <= rx_byte;
        end
    end

    // 00h lives here so the shifter sees new settings on the next bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg    <= dscp_pkg::CFG_RESET;
            soft_reset <= 1'b0;
        end else begin
            soft_reset <= cfg_hit && rx_byte[dscp_pkg::CFG_SRST_BIT];
            if (cfg_hit) begin
                cfg_reg <= rx_byte;
            end
        end
    end

    // soft reset leaves 00h alone since it is held outside the array
    dscp_regfile u_regs (
        .clk     (clk),
        .rst_n   (rst_n),
        .wr      (reg_wr),
        .clr     (soft_reset),
        .rd_addr (addr_q),
        .rd_data (rd_mem)
    );

    // ------------------------------------------------------------
    // read data launch and pin drive
    // ------------------------------------------------------------
    assign tx_byte = (addr_q == dscp_pkg::CFG_ADDR) ? cfg_reg : rd_mem;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_phase_q <= 1'b0;
            sdio_o     <= 1'b0;
        end else begin
            rd_phase_q <= ~cs_hi && state_q != dscp_pkg::DSCP_INSTR && ins_q.rd;
            if (fall) begin
                // bit_q already counts this byte's received edges
                sdio_o <= lsb_first ? tx_byte[bit_q] : tx_byte[3'(7 - bit_q)];
            end
        end
    end

    assign serial_data_out_pin_o = sdio_o;

    // enables are registered and gated by synchronised select, so the pins float one clock after cs_hi rises
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdio_oe                <= 1'b0;
            serial_data_out_pin_oe <= 1'b0;
        end else begin
            sdio_oe                <= ~cs_hi & rd_phase_q & bidir;
            serial_data_out_pin_oe <= ~cs_hi & rd_phase_q & ~bidir;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    float_cs_a: assert property (@(posedge clk) disable iff (!rst_n)
        cs_hi |=> !sdio_oe && !serial_data_out_pin_oe)
        else $error("data pins driven while select high");

    bidir_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(bidir) |-> !serial_data_out_pin_oe)
        else $error("output pin driven in bidirectional mode");

    wrap_up_a: assert property (@(posedge clk) disable iff (!rst_n)
        byte_done && state_q == dscp_pkg::DSCP_DATA && next_addr == 5'h00 && addr_q == 5'h1f
        |=> addr_q == 5'h00)
        else $error("increment wrap wrong");

    step_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
        byte_done && state_q == dscp_pkg::DSCP_DATA && !ins_q.rd && addr_q != 5'h00 && !lsb_first
        && !cfg_hit |=> addr_q == 5'($past(addr_q) - 5'd1))
        else $error("msb first address did not decrement");

    byte_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cycle |=> reg_wr.stb && reg_wr.data == $past(rx_byte))
        else $error("byte not written on its last bit");

    restart_a: assert property (@(posedge clk) disable iff (!rst_n)
        cs_hi |=> bit_q == 3'd0 && state_q == dscp_pkg::DSCP_INSTR)
        else $error("select high did not restart port");

    launch_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(sdio_o) |-> $past(fall))
        else $error("read bit changed off a falling edge");

    cfg_apply_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_hit |=> lsb_first == $past(rx_byte[dscp_pkg::CFG_LSB_BIT])
                    && bidir == $past(rx_byte[dscp_pkg::CFG_BIDIR_BIT]))
        else $error("configuration not applied at once");

    soft_rst_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset |=> cfg_reg == $past(cfg_reg))
        else $error("soft reset altered register 00h");

    idle_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
        cs_hi |-> !rise && !fall)
        else $error("shifting while deselected");

endmodule

`default_nettype wire

// ---- verif/dscp_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// serial master standing in for the host
// ------------------------------------------------------------
module dscp_host_model (
    input  wire logic clk,
    input  wire logic miso,
    output logic      sclk,
    output logic      sel_n,
    output logic      mosi,
    output logic      mosi_oe
);
    // idle: clock parked low between frames, select high
    initial begin
        sclk    = 1'b0;
        sel_n   = 1'b1;
        mosi    = 1'b0;
        mosi_oe = 1'b0;
    end

    // every change lands just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // select stays low from first instruction bit to last data bit
    task automatic start();
        tick(1);
        sel_n = 1'b0;
        tick(5);
    endtask

    // 80 ns per bit keeps the link slow enough for the device sampler
    task automatic shift(input logic [7:0] b, input logic lsb, input int nb,
                         input logic drv, input logic rel, output logic [7:0] r);
        int idx;
        r = 8'h00;
        for (int i = 0; i < nb; i++) begin
            idx     = lsb ? i : 7 - i;
            mosi    = b[idx];
            mosi_oe = drv;
            tick(5);
            sclk   = 1'b1;
            r[idx] = miso;
            if (rel && i == nb - 1) begin
                // hold past the sampler's first flop, let go before the turn
                tick(2);
                mosi_oe = 1'b0;
                tick(3);
            end else begin
                tick(5);
            end
            sclk = 1'b0;
        end
    endtask

    // end of frame, partial bytes included
    task automatic stop();
        tick(5);
        sel_n   = 1'b1;
        mosi_oe = 1'b0;
        tick(6);
    endtask

    // clock pulses while deselected
    task automatic idle_clocks(input int n);
        repeat (n) begin
            tick(5);
            sclk = 1'b1;
            tick(5);
            sclk = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic               clk, rst_n, sclk, sel_n, mosi, mosi_oe, miso;
    logic               sdio_o, sdio_oe, sop_o, sop_oe, soft_reset;
    logic [7:0]         cfg_reg, r8;
    logic [31:0]        rv;
    dscp_pkg::dscp_wr_t reg_wr;
    logic               float_q, sdio_w, sop_w, bidir, lsb, sop_seen, sdio_seen;
    logic [12:0]        wr_q[$];
    int                 mismatches, num_checks, srst_cnt;

    // ------------------------------------------------------------
    // pins: an undriven line toggles, contention shows x
    // ------------------------------------------------------------
    assign sdio_w = (sdio_oe && mosi_oe) ? 1'bx : sdio_oe ? sdio_o : mosi_oe ? mosi : float_q;
    assign sop_w  = sop_oe ? sop_o : float_q;
    assign miso   = bidir ? sdio_w : sop_w;

    always #4 clk = ~clk;

    // watch write pulses, reset pulses and pin drivers
    always @(posedge clk) begin
        float_q <= ~float_q;
        if (reg_wr.stb === 1'b1) wr_q.push_back({reg_wr.addr, reg_wr.data});
        if (soft_reset === 1'b1) srst_cnt++;
        if (sop_oe === 1'b1) sop_seen = 1'b1;
        if (sdio_oe === 1'b1) sdio_seen = 1'b1;
    end

    dscp_port i_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .port_select_n(sel_n),
        .sdio_i(sdio_w), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_data_out_pin_o(sop_o),
        .serial_data_out_pin_oe(sop_oe), .cfg_reg(cfg_reg), .reg_wr(reg_wr),
        .soft_reset(soft_reset));
    dscp_host_model i_host (.clk(clk), .miso(miso), .sclk(sclk), .sel_n(sel_n),
        .mosi(mosi), .mosi_oe(mosi_oe));

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic check1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic check13(input string n, input logic [12:0] e, input logic [12:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one whole cycle; nexp below zero skips the write count (00h writes)
    task automatic xfer(input logic rd, input logic [1:0] cm1, input logic [4:0] a,
                        input logic [31:0] wd, input int nexp, output logic [31:0] r);
        logic [7:0] b;
        r = 32'h0;
        wr_q.delete();
        sop_seen  = 1'b0;
        sdio_seen = 1'b0;
        i_host.start();
        i_host.shift({rd, cm1, a}, lsb, 8, 1'b1, rd, b);
        for (int k = 0; k <= int'(cm1); k++) begin
            i_host.shift(wd[8*k +: 8], lsb, 8, !rd, 1'b0, b);
            r[8*k +: 8] = b;
        end
        if (nexp >= 0) check8("writes before select rise", 8'(nexp), 8'(wr_q.size()));
        i_host.stop();
        check1("sdio_oe deselected", 1'b0, sdio_oe);
        check1("separate pin oe deselected", 1'b0, sop_oe);
    endtask

    // watchdog: a hang ends the run as a failure
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        float_q = 1'b0;
        bidir = 1'b0;
        lsb = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        i_host.tick(3);
        check8("cfg_reg after reset", 8'h00, cfg_reg);
        xfer(1'b0, 2'd1, 5'h05, 32'h3ca5, 2, rv);
        check13("first write", {5'h05, 8'ha5}, wr_q[0]);
        check13("second write", {5'h04, 8'h3c}, wr_q[1]);
        xfer(1'b0, 2'd0, 5'h1f, 32'h77, 1, rv);
        xfer(1'b1, 2'd1, 5'h00, 32'h0, 0, rv);
        check8("read 00h", 8'h00, rv[7:0]);
        check8("read after wrap down", 8'h77, rv[15:8]);
        check1("separate pin drove", 1'b1, sop_seen);
        check1("shared pin idle", 1'b0, sdio_seen);
        xfer(1'b0, 2'd0, 5'h00, 32'hc0, -1, rv);
        check8("cfg_reg", 8'hc0, cfg_reg);
        check8("soft resets", 8'h00, 8'(srst_cnt));
        lsb = 1'b1;
        bidir = 1'b1;
        xfer(1'b0, 2'd1, 5'h10, 32'h2211, 2, rv);
        check13("first lsb write", {5'h10, 8'h11}, wr_q[0]);
        check13("second lsb write", {5'h11, 8'h22}, wr_q[1]);
        xfer(1'b1, 2'd1, 5'h1f, 32'h0, 0, rv);
        check8("read 1fh", 8'h77, rv[7:0]);
        check8("read after wrap up", 8'hc0, rv[15:8]);
        check1("shared pin drove", 1'b1, sdio_seen);
        check1("separate pin idle", 1'b0, sop_seen);
        // partial instruction, then partial data byte, then deselected clocks
        wr_q.delete();
        i_host.start();
        i_host.shift(8'h0a, 1'b1, 4, 1'b1, 1'b0, r8);
        i_host.stop();
        i_host.start();
        i_host.shift(8'h0a, 1'b1, 8, 1'b1, 1'b0, r8);
        i_host.shift(8'h5a, 1'b1, 7, 1'b1, 1'b0, r8);
        i_host.stop();
        i_host.idle_clocks(8);
        check8("writes after aborts", 8'h00, 8'(wr_q.size()));
        xfer(1'b0, 2'd0, 5'h0a, 32'h5a, 1, rv);
        check13("write after abort", {5'h0a, 8'h5a}, wr_q[0]);
        xfer(1'b0, 2'd0, 5'h00, 32'he7, -1, rv);
        check8("cfg_reg mirrored", 8'he7, cfg_reg);
        check8("soft resets", 8'h01, 8'(srst_cnt));
        xfer(1'b1, 2'd0, 5'h0a, 32'h0, 0, rv);
        check8("read 0ah after soft reset", 8'h00, rv[7:0]);
        xfer(1'b0, 2'd0, 5'h00, 32'h24, -1, rv);
        lsb = 1'b0;
        bidir = 1'b0;
        check8("cfg_reg mirrored back", 8'h24, cfg_reg);
        check8("soft resets", 8'h02, 8'(srst_cnt));
        xfer(1'b1, 2'd0, 5'h00, 32'h0, 0, rv);
        check8("read 00h msb first", 8'h24, rv[7:0]);
        complete_run();
    end
endmodule

`default_nettype wire
